// *** pkg/mlbd_pkg.sv ***
// Shared constants and types of the MAC loopback diagnostic block.
// Assumes a 32-bit classic Wishbone register bus and byte-wide buffer memory.
package mlbd_pkg;

   // ****************************************************************
   // FIFO geometry
   // ****************************************************************
   localparam int unsigned HALF_DEPTH = 8;
   localparam int unsigned PTR_W = 3;

   // ****************************************************************
   // Register offsets (byte addresses)
   // ****************************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TX_PAGE = 8'h04;
   localparam logic [7:0] OFS_TX_COUNT = 8'h08;
   localparam logic [7:0] OFS_THRESH = 8'h0c;
   localparam logic [7:0] OFS_IRQ = 8'h10;
   localparam logic [7:0] OFS_RX_STATUS = 8'h14;
   localparam logic [7:0] OFS_TX_STATUS = 8'h18;
   localparam logic [7:0] OFS_RX_COUNT = 8'h1c;
   localparam logic [7:0] OFS_FIFO = 8'h20;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int unsigned CTRL_LOOP_LSB = 0;
   localparam int unsigned CTRL_CRC_INH = 2;
   localparam int unsigned CTRL_WORD = 3;
   localparam int unsigned CTRL_BYTE_ORDER = 4;
   localparam int unsigned CTRL_GO = 7;
   localparam int unsigned CTRL_BUSY = 8;
   localparam int unsigned IRQ_RX_INTACT = 0;
   localparam int unsigned IRQ_TX_DONE = 1;
   localparam int unsigned RSR_INTACT = 0;
   localparam int unsigned RSR_CRC_ERR = 1;
   localparam int unsigned TSR_OK = 0;
   localparam int unsigned TSR_CARRIER_LOST = 4;
   localparam int unsigned TSR_HEARTBEAT_FAIL = 6;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [4:0] CTRL_RST = 5'h00;
   localparam logic [7:0] TX_PAGE_RST = 8'h00;
   localparam logic [15:0] TX_COUNT_RST = 16'h0000;
   localparam logic [3:0] THRESH_RST = 4'h4;

   // ****************************************************************
   // Frame and timing constants
   // ****************************************************************
   localparam int unsigned PRE_BITS = 56;
   localparam int unsigned SFD_BITS = 8;
   localparam int unsigned CRC_BITS = 32;
   localparam int unsigned FIFO_ADV_CYCLES = 4;
   localparam logic [7:0] SFD_PATTERN = 8'hd5;
   localparam logic [31:0] CRC_POLY = 32'h04c11db7;
   localparam logic [31:0] CRC_INIT = 32'hffffffff;
   localparam logic [31:0] CRC_RESIDUE = 32'hc704dd7b;

   typedef enum logic [1:0] {
      LOOP_OFF = 2'h0,
      LOOP_INT = 2'h1,
      LOOP_ENC = 2'h2,
      LOOP_COAX = 2'h3
   } mlbd_loop_t;

   typedef enum logic [4:0] {
      TX_IDLE = 5'h01,
      TX_DEFER = 5'h02,
      TX_PRE = 5'h04,
      TX_DATA = 5'h08,
      TX_CRC = 5'h10
   } mlbd_tx_t;

endpackage : mlbd_pkg

// *** src/mlbd_crc.sv ***
// Bit-serial CRC-32 register, first data bit first.
// Assumes bits arrive one per enable; init has priority over enable.
`timescale 1ns/1ps
`default_nettype none
module mlbd_crc
   import mlbd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic init_i,
   input wire logic en_i,
   input wire logic bit_i,
   output logic [31:0] crc_o
);

   // ****************************************************************
   // Shift register
   // ****************************************************************
   function automatic logic [31:0] crc_step(input logic [31:0] c,
                                            input logic b);
      crc_step = {c[30:0], 1'b0} ^ ((c[31] ^ b) ? CRC_POLY : 32'h00000000);
   endfunction : crc_step

   always_ff @(posedge clk_i) begin
      if (rst_i || init_i) begin
         crc_o <= CRC_INIT;
      end else if (en_i) begin
         crc_o <= crc_step(crc_o, bit_i);
      end
   end

endmodule : mlbd_crc
`default_nettype wire

// *** src/mlbd_top.sv ***
// Loopback diagnostic logic of a CSMA/CD MAC: DMA, split FIFO, serializer,
// deserializer and the FIFO read port.
// Assumes a classic Wishbone master, byte-wide asynchronous buffer memory
// and a serial encoder/decoder whose pins are asynchronous to clk_i.
//
// How it works
// - Internal mode loops serializer into deserializer
// - Encoder mode drives external loop control
// - Coax mode sends packet onto medium
// - Mask carrier/collision reporting, still defer
// - FIFO split into transmit and receive halves
// - Loopback DMA fetches bytes only
// - FIFO read pointer advances, wait states
// - Receive bytes wrap over eight locations
// - Append lower, upper, upper byte count
// - DMA fills FIFO, refills below threshold
// - Send preamble and sync before data
// - CRC appended unless inhibited
// - Set transmit done flag at end
// - Packet received flag stays zero
// - Strip preamble, store and count bytes
// - CRC check or forced error on match
// - Receive status written, intact normally set
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mlbd_top
   import mlbd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic bus_request_o,
   input wire logic bus_grant_i,
   output logic [15:0] mem_addr_o,
   output logic mem_rd_o,
   input wire logic [7:0] mem_data_i,
   input wire logic tx_clk_i,
   output logic tx_data_o,
   output logic tx_en_o,
   input wire logic rx_clk_i,
   input wire logic rx_data_i,
   input wire logic carrier_i,
   input wire logic collision_i,
   input wire logic addr_match_i,
   output logic ext_loop_ctl_o
);
   import mlbd_pkg::*;

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   logic [5:0] sync1, sync2, sync3;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1 <= 6'h00;
         sync2 <= 6'h00;
         sync3 <= 6'h00;
      end else begin
         sync1 <= {bus_grant_i, collision_i, carrier_i, rx_data_i,
                   rx_clk_i, tx_clk_i};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end
   logic tx_tick, rx_edge, rx_bit_s, car_s, col_s, grant_s;
   assign tx_tick = sync2[0] & ~sync3[0];
   assign rx_edge = sync2[1] & ~sync3[1];
   assign rx_bit_s = sync2[2];
   assign car_s = sync2[3];
   assign col_s = sync2[4];
   assign grant_s = sync2[5];

   // ****************************************************************
   // Registers and state
   // ****************************************************************
   logic [4:0] ctrl;
   logic [7:0] tx_page_start;
   logic [15:0] tx_count;
   logic [3:0] thresh;
   logic tx_done_flag;
   logic [1:0] rx_status_reg;
   logic [2:0] tx_status;
   logic [15:0] rx_count;
   logic [7:0] fifo_mem [2*HALF_DEPTH];
   mlbd_tx_t state;
   mlbd_loop_t loop_mode;
   logic crc_inh, word_mode, byte_order;
   assign loop_mode = mlbd_loop_t'(ctrl[CTRL_LOOP_LSB +: 2]);
   assign crc_inh = ctrl[CTRL_CRC_INH];
   assign word_mode = ctrl[CTRL_WORD];
   assign byte_order = ctrl[CTRL_BYTE_ORDER];

   logic wb_req, wb_wr, wb_rd, fifo_rd, fifo_stall, go_start, tx_done_evt;
   logic [2:0] adv_cnt;
   logic [PTR_W-1:0] rd_ptr, twr, trd, rx_wr;
   logic [3:0] tx_level;
   logic [15:0] dma_addr, dma_cnt;
   logic dma_phase, push, pop;
   logic [1:0] tail;
   logic [31:0] tx_crc, rx_crc;
   logic rx_synced;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a[7:2] == o[7:2]);
   endfunction : hit

   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign fifo_stall = hit(wb_adr_i, OFS_FIFO) & ~wb_we_i &
                       (adv_cnt != 3'h0);
   assign wb_wr = wb_req & wb_we_i;
   assign wb_rd = wb_req & ~wb_we_i & ~fifo_stall;
   assign fifo_rd = wb_rd & hit(wb_adr_i, OFS_FIFO);
   assign go_start = wb_wr & wb_sel_i[0] & hit(wb_adr_i, OFS_CTRL) &
                     wb_dat_i[CTRL_GO] & (state == TX_IDLE);

   // ****************************************************************
   // Wishbone slave
   // ****************************************************************
   logic [31:0] rdata;
   always_comb begin
      rdata = 32'h00000000;
      case (wb_adr_i[7:2])
         OFS_CTRL[7:2]: rdata = {23'h000000, state != TX_IDLE, 3'h0, ctrl};
         OFS_TX_PAGE[7:2]: rdata = {24'h000000, tx_page_start};
         OFS_TX_COUNT[7:2]: rdata = {16'h0000, tx_count};
         OFS_THRESH[7:2]: rdata = {28'h0000000, thresh};
         OFS_IRQ[7:2]: rdata = {30'h00000000, tx_done_flag, 1'b0};
         OFS_RX_STATUS[7:2]: rdata = {30'h00000000, rx_status_reg};
         OFS_TX_STATUS[7:2]: rdata = {25'h0000000, tx_status[2], 1'b0,
                                      tx_status[1], 3'h0, tx_status[0]};
         OFS_RX_COUNT[7:2]: rdata = {16'h0000, rx_count};
         OFS_FIFO[7:2]: rdata = {24'h000000,
                                 fifo_mem[HALF_DEPTH + 32'(rd_ptr)]};
         default: rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_wr | wb_rd;
         if (wb_rd) begin
            wb_dat_o <= rdata;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= CTRL_RST;
         tx_page_start <= TX_PAGE_RST;
         tx_count <= TX_COUNT_RST;
         thresh <= THRESH_RST;
      end else if (wb_wr) begin
         if (hit(wb_adr_i, OFS_CTRL) && wb_sel_i[0]) begin
            ctrl <= wb_dat_i[4:0];
         end
         if (hit(wb_adr_i, OFS_TX_PAGE) && wb_sel_i[0]) begin
            tx_page_start <= wb_dat_i[7:0];
         end
         if (hit(wb_adr_i, OFS_TX_COUNT)) begin
            if (wb_sel_i[0]) begin
               tx_count[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               tx_count[15:8] <= wb_dat_i[15:8];
            end
         end
         if (hit(wb_adr_i, OFS_THRESH) && wb_sel_i[0]) begin
            thresh <= wb_dat_i[3:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_done_flag <= 1'b0;
      end else if (tx_done_evt) begin
         tx_done_flag <= 1'b1;
      end else if (wb_wr && wb_sel_i[0] && hit(wb_adr_i, OFS_IRQ) &&
                   wb_dat_i[IRQ_TX_DONE]) begin
         tx_done_flag <= 1'b0;
      end
   end

   // Loop control only in encoder mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_loop_ctl_o <= 1'b0;
      end else begin
         ext_loop_ctl_o <= (loop_mode == LOOP_ENC);
      end
   end

   // ****************************************************************
   // Transmit DMA into the lower FIFO half
   // ****************************************************************
   function automatic logic lane_ok(input logic wm, input logic bo,
                                    input logic a0);
      lane_ok = ~wm | (a0 == ~bo);
   endfunction : lane_ok

   assign push = dma_phase & lane_ok(word_mode, byte_order, mem_addr_o[0]);

   // Burst until full, rearm below threshold
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_request_o <= 1'b0;
         mem_rd_o <= 1'b0;
         mem_addr_o <= 16'h0000;
         dma_addr <= 16'h0000;
         dma_cnt <= 16'h0000;
         dma_phase <= 1'b0;
      end else if (go_start) begin
         dma_addr <= {tx_page_start, 8'h00};
         dma_cnt <= tx_count;
         dma_phase <= 1'b0;
         bus_request_o <= 1'b0;
      end else if (dma_phase) begin
         mem_rd_o <= 1'b0;
         dma_phase <= 1'b0;
         dma_addr <= dma_addr + 16'h0001;
         dma_cnt <= dma_cnt - 16'h0001;
      end else if (!bus_request_o) begin
         bus_request_o <= (state != TX_IDLE) && (dma_cnt != 16'h0000) &&
                          (tx_level < thresh);
      end else if (grant_s) begin
         if (dma_cnt != 16'h0000 && tx_level < 4'(HALF_DEPTH)) begin
            mem_rd_o <= 1'b1;
            mem_addr_o <= dma_addr;
            dma_phase <= 1'b1;
         end else begin
            bus_request_o <= 1'b0;
         end
      end
   end

   // Lower half transmit, upper half receive
   logic rx_we;
   logic [7:0] rx_wd;
   always_ff @(posedge clk_i) begin
      if (push) begin
         fifo_mem[32'(twr)] <= mem_data_i;
      end
      if (rx_we) begin
         fifo_mem[HALF_DEPTH + 32'(rx_wr)] <= rx_wd;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || go_start) begin
         twr <= '0;
         trd <= '0;
         tx_level <= 4'h0;
      end else begin
         if (push) begin
            twr <= twr + 3'h1;
         end
         if (pop) begin
            trd <= trd + 3'h1;
         end
         tx_level <= tx_level + {3'h0, push} - {3'h0, pop};
      end
   end

   // ****************************************************************
   // Serializer
   // ****************************************************************
   logic [5:0] bit_cnt;
   logic [2:0] bit_idx;
   logic [7:0] tx_sh, head;
   logic [31:0] crc_sh;
   logic tx_ready, in_data, tx_bit_next, crs_seen, col_seen;
   assign head = fifo_mem[32'(trd)];
   assign tx_ready = (tx_level == 4'(HALF_DEPTH)) ||
                     (dma_cnt == 16'h0000 && !dma_phase);
   assign in_data = tx_tick && (state == TX_DATA);
   assign pop = in_data && (bit_idx == 3'h0) && (tx_level != 4'h0);
   assign tx_bit_next = (bit_idx == 3'h0) ? head[0] : tx_sh[bit_idx];

   function automatic logic pre_bit(input logic [5:0] n);
      pre_bit = (n < 6'(PRE_BITS)) ? ~n[0] : SFD_PATTERN[n[2:0]];
   endfunction : pre_bit

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= TX_IDLE;
         tx_en_o <= 1'b0;
         tx_data_o <= 1'b0;
         bit_cnt <= 6'h00;
         bit_idx <= 3'h0;
         tx_sh <= 8'h00;
         crc_sh <= 32'h00000000;
         tx_done_evt <= 1'b0;
      end else begin
         tx_done_evt <= 1'b0;
         case (state)
            TX_IDLE: begin
               if (go_start) begin
                  state <= TX_DEFER;
               end
            end
            // Defer on raw carrier and collision
            TX_DEFER: begin
               if (tx_ready && !car_s && !col_s && tx_tick) begin
                  state <= TX_PRE;
                  tx_en_o <= 1'b1;
                  tx_data_o <= pre_bit(6'h00);
                  bit_cnt <= 6'h01;
               end
            end
            TX_PRE: begin
               if (tx_tick) begin
                  tx_data_o <= pre_bit(bit_cnt);
                  bit_cnt <= bit_cnt + 6'h01;
                  if (bit_cnt == 6'(PRE_BITS + SFD_BITS - 1)) begin
                     state <= TX_DATA;
                     bit_idx <= 3'h0;
                  end
               end
            end
            TX_DATA: begin
               if (in_data) begin
                  if (bit_idx != 3'h0 || tx_level != 4'h0) begin
                     tx_data_o <= tx_bit_next;
                     bit_idx <= bit_idx + 3'h1;
                     if (bit_idx == 3'h0) begin
                        tx_sh <= head;
                     end
                  // Inhibit ends on last FIFO byte
                  end else if (crc_inh) begin
                     state <= TX_IDLE;
                     tx_en_o <= 1'b0;
                     tx_done_evt <= 1'b1;
                  end else begin
                     state <= TX_CRC;
                     tx_data_o <= ~tx_crc[31];
                     crc_sh <= {~tx_crc[30:0], 1'b0};
                     bit_cnt <= 6'h01;
                  end
               end
            end
            TX_CRC: begin
               if (tx_tick) begin
                  if (bit_cnt == 6'(CRC_BITS)) begin
                     state <= TX_IDLE;
                     tx_en_o <= 1'b0;
                     tx_done_evt <= 1'b1;
                  end else begin
                     tx_data_o <= crc_sh[31];
                     crc_sh <= {crc_sh[30:0], 1'b0};
                     bit_cnt <= bit_cnt + 6'h01;
                  end
               end
            end
            default: state <= TX_IDLE;
         endcase
      end
   end

   mlbd_crc u_tx_crc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .init_i(go_start),
      .en_i(in_data && (bit_idx != 3'h0 || tx_level != 4'h0)),
      .bit_i(tx_bit_next),
      .crc_o(tx_crc)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         crs_seen <= 1'b0;
         col_seen <= 1'b0;
         tx_status <= 3'h0;
      end else if (go_start) begin
         crs_seen <= 1'b0;
         col_seen <= 1'b0;
      end else begin
         if (tx_en_o && car_s && loop_mode != LOOP_INT) begin
            crs_seen <= 1'b1;
         end
         if (tx_en_o && col_s && (loop_mode == LOOP_COAX ||
                                  loop_mode == LOOP_OFF)) begin
            col_seen <= 1'b1;
         end
         if (tx_done_evt) begin
            tx_status <= {~col_seen, ~crs_seen, 1'b1};
         end
      end
   end

   // ****************************************************************
   // Deserializer into the upper FIFO half
   // ****************************************************************
   // Internal uses transmit clock and bit
   logic frame, frame_d, rx_tick, rx_bit;
   logic [7:0] rx_sh, rx_next;
   logic [2:0] rx_bits;
   assign frame = (loop_mode == LOOP_INT) ? tx_en_o : car_s;
   assign rx_tick = (loop_mode == LOOP_INT) ? (tx_tick & tx_en_o)
                                            : (rx_edge & car_s);
   assign rx_bit = (loop_mode == LOOP_INT) ? tx_data_o : rx_bit_s;
   assign rx_next = {rx_bit, rx_sh[7:1]};
   assign rx_we = (rx_tick && rx_synced && rx_bits == 3'h7) || tail != 2'h0;
   assign rx_wd = (tail == 2'h1) ? rx_count[7:0] :
                  (tail != 2'h0) ? rx_count[15:8] : rx_next;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frame_d <= 1'b0;
         rx_synced <= 1'b0;
         rx_sh <= 8'h00;
         rx_bits <= 3'h0;
         rx_wr <= '0;
         rx_count <= 16'h0000;
         tail <= 2'h0;
         rx_status_reg <= 2'h0;
      end else begin
         frame_d <= frame;
         if (frame && !frame_d) begin
            rx_synced <= 1'b0;
            rx_sh <= 8'h00;
            rx_bits <= 3'h0;
            rx_wr <= '0;
            rx_count <= 16'h0000;
         end else if (!frame && frame_d && rx_synced) begin
            rx_synced <= 1'b0;
            tail <= 2'h1;
         // Hunt sync, then store and count
         end else if (rx_tick) begin
            rx_sh <= rx_next;
            if (!rx_synced) begin
               rx_synced <= (rx_next == SFD_PATTERN);
            end else begin
               rx_bits <= rx_bits + 3'h1;
               if (rx_bits == 3'h7) begin
                  rx_wr <= rx_wr + 3'h1;
                  rx_count <= rx_count + 16'h0001;
               end
            end
         end
         if (tail != 2'h0) begin
            rx_wr <= rx_wr + 3'h1;
            tail <= (tail == 2'h3) ? 2'h0 : tail + 2'h1;
         end
         if (tail == 2'h3) begin
            rx_status_reg[RSR_CRC_ERR] <=
               (crc_inh || rx_crc != CRC_RESIDUE) && addr_match_i;
            rx_status_reg[RSR_INTACT] <=
               !((crc_inh || rx_crc != CRC_RESIDUE) && addr_match_i);
         end
      end
   end

   mlbd_crc u_rx_crc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .init_i(frame && !frame_d),
      .en_i(rx_tick && rx_synced),
      .bit_i(rx_bit),
      .crc_o(rx_crc)
   );

   // ****************************************************************
   // FIFO read port; pointer lags each read by a few cycles
   // ****************************************************************
   // Delayed pointer advance
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_ptr <= '0;
         adv_cnt <= 3'h0;
      end else if (tail == 2'h3) begin
         rd_ptr <= rx_wr + 3'h1;
         adv_cnt <= 3'h0;
      end else if (fifo_rd) begin
         adv_cnt <= 3'(FIFO_ADV_CYCLES);
      end else if (adv_cnt != 3'h0) begin
         adv_cnt <= adv_cnt - 3'h1;
         if (adv_cnt == 3'h1) begin
            rd_ptr <= rd_ptr + 3'h1;
         end
      end
   end

endmodule : mlbd_top
`default_nettype wire

// *** tb/mlbd_checker.sv ***
// Port checks of the loopback block.
// Assumes it is bound into mlbd_top.
`timescale 1ns/1ps
`default_nettype none
module mlbd_checker
   import mlbd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic bus_request_o,
   input wire logic [15:0] mem_addr_o,
   input wire logic mem_rd_o,
   input wire logic ext_loop_ctl_o
);
   logic [1:0] loop;
   // Shadow of the loop field, taken at the write's ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loop <= 2'h0;
      end else if (wb_ack_o && wb_we_i && wb_adr_i == OFS_CTRL) begin
         loop <= wb_dat_i[1:0];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence byte_pair;
      mem_rd_o ##2 mem_rd_o;
   endsequence
   loop_ctl_a: assert property ($stable(loop) [*3] |->
      ext_loop_ctl_o == (loop == LOOP_ENC)) else $error("loop control");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   ack_cause_a: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
      else $error("ack without request");
   fifo_wait_a: assert property ($rose(wb_stb_i) &&
      wb_adr_i == OFS_FIFO |-> ##[1:5] wb_ack_o) else $error("fifo hang");
   rx_flag_zero_a: assert property (wb_ack_o && !wb_we_i &&
      wb_adr_i == OFS_IRQ |-> !wb_dat_o[IRQ_RX_INTACT]) else $error("rx flag");
   rd_pulse_a: assert property (mem_rd_o |=> !mem_rd_o)
      else $error("read strobe long");
   rd_granted_a: assert property (mem_rd_o |-> bus_request_o)
      else $error("read without request");
   addr_step_a: assert property (byte_pair |->
      mem_addr_o == $past(mem_addr_o, 2) + 16'h1) else $error("addr step");
endmodule : mlbd_checker
bind mlbd_top mlbd_checker i_chk (.*);
`default_nettype wire

// *** tb/mlbd_partner.sv ***
// Buffer memory, arbiter and serial encoder/decoder model.
// Assumes clk_i is the block's clock.
`timescale 1ns/1ps
`default_nettype none
module mlbd_partner (
   input wire logic clk_i,
   input wire logic bus_request_i,
   input wire logic [15:0] mem_addr_i,
   input wire logic mem_rd_i,
   input wire logic tx_clk_i,
   input wire logic tx_data_i,
   input wire logic tx_en_i,
   input wire logic ext_loop_ctl_i,
   output logic bus_grant_o,
   output logic [7:0] mem_data_o,
   output logic rx_clk_o,
   output logic rx_data_o,
   output logic carrier_o
);
   logic [2:0] gq = 3'h0;
   // Grant after 3 cycles, far inside 2 us
   always @(posedge clk_i) gq <= {gq[1:0], bus_request_i};
   assign bus_grant_o = gq[2] & bus_request_i;
   // Data lines show inverted garbage when not read
   assign mem_data_o = (mem_addr_i[7:0] ^ 8'h5a) ^ {8{~mem_rd_i}};
   // Loop clock and carrier back only when told; data loops back inverted when not told
   assign rx_clk_o = ext_loop_ctl_i & tx_clk_i;
   assign rx_data_o = ext_loop_ctl_i ? tx_data_i : ~tx_data_i;
   assign carrier_o = ext_loop_ctl_i & tx_en_i;
endmodule : mlbd_partner
`default_nettype wire

// *** tb/tb_mac_loopback_diagnostics.sv ***
// Self-checking bench of the loopback block.
// Assumes mlbd_top, the partner model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_mac_loopback_diagnostics;
   import mlbd_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, tx_clk_i = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0, q;
   logic collision_i = 1'b0, addr_match_i = 1'b1;
   wire [31:0] wb_dat_o;
   wire [15:0] mem_addr_o;
   wire [7:0] mem_data_i;
   wire wb_ack_o, bus_request_o, bus_grant_i, mem_rd_o, tx_data_o;
   wire tx_en_o, rx_clk_i, rx_data_i, carrier_i, ext_loop_ctl_o;
   int n_errors = 0, samples_checked = 0;
   always #50 clk_i = ~clk_i;
   mlbd_top i_dut (.*);
   mlbd_partner i_far (.clk_i(clk_i), .bus_request_i(bus_request_o),
      .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o), .tx_clk_i(tx_clk_i),
      .tx_data_i(tx_data_o), .tx_en_i(tx_en_o),
      .ext_loop_ctl_i(ext_loop_ctl_o), .bus_grant_o(bus_grant_i),
      .mem_data_o(mem_data_i), .rx_clk_o(rx_clk_i),
      .rx_data_o(rx_data_i), .carrier_o(carrier_i));
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
      // Request stands until the edge that samples ack high
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
   endtask : wb
   task automatic chk(input logic [7:0] nm, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] item %h expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(a, e, q);
   endtask : rd
   task automatic mode(input logic [7:0] m, input logic e);
      wb(1'b1, OFS_CTRL, {24'h0, m});
      repeat (3) @(negedge clk_i);
      chk(8'hff, {31'h0, e}, {31'h0, ext_loop_ctl_o});
   endtask : mode
   task automatic frame(input logic [7:0] ctl, input logic [31:0] nb);
      wb(1'b1, OFS_TX_PAGE, 32'h1);
      wb(1'b1, OFS_TX_COUNT, nb);
      wb(1'b1, OFS_CTRL, {24'h0, ctl | 8'h80});
      do wb(1'b0, OFS_CTRL, 32'h0); while (q[CTRL_BUSY] !== 1'b0);
      rd(OFS_IRQ, 32'h2);
      wb(1'b1, OFS_IRQ, 32'h2);
   endtask : frame
   task automatic t_reset;
      rd(OFS_CTRL, 32'h0);
      rd(OFS_THRESH, 32'h4);
      rd(8'h3c, 32'h0);
      mode(8'h03, 1'b0);
      mode(8'h00, 1'b0);
   endtask : t_reset
   task automatic t_internal;
      mode(8'h05, 1'b0);
      frame(8'h05, 32'd13);
      rd(OFS_RX_STATUS, 32'h2);
      rd(OFS_RX_COUNT, 32'd13);
      rd(OFS_TX_STATUS, 32'h51);
      for (int i = 8; i < 13; i++) rd(OFS_FIFO, 32'(i) ^ 32'h5a);
      rd(OFS_FIFO, 32'd13);
      rd(OFS_FIFO, 32'h0);
      rd(OFS_FIFO, 32'h0);
      rd(OFS_IRQ, 32'h0);
      mode(8'h00, 1'b0);
   endtask : t_internal
   task automatic t_encoder;
      mode(8'h02, 1'b1);
      // Word mode, even lanes: ten fetches carry five bytes
      frame(8'h1a, 32'd10);
      rd(OFS_RX_COUNT, 32'd9);
      rd(OFS_RX_STATUS, 32'h1);
      rd(OFS_TX_STATUS, 32'h41);
      mode(8'h00, 1'b0);
      mode(8'h03, 1'b0);
      frame(8'h07, 32'd2);
      rd(OFS_TX_STATUS, 32'h51);
      mode(8'h00, 1'b0);
   endtask : t_encoder
   task automatic end_sim;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim
   initial begin
      #130;
      forever #400 tx_clk_i = ~tx_clk_i;
   end
   initial begin
      #3000000;
      n_errors++;
      end_sim();
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_internal();
      t_encoder();
      end_sim();
   end
endmodule : tb_mac_loopback_diagnostics
`default_nettype wire
